// ==== rtl/fan_ctrl_params.svh ====
// constants of the fan controller register and fault logic
`ifndef FAN_CTRL_PARAMS_SVH
`define FAN_CTRL_PARAMS_SVH
// register pointer codes
`define PTR_FAULT 3'h0
`define PTR_STATUS 3'h1
`define PTR_LVL_A 3'h2
`define PTR_LVL_B 3'h3
`define PTR_CNT_A 3'h4
`define PTR_CNT_B 3'h5
`define PTR_PIN_STATE 3'h6
`define PTR_PIN_SETUP 3'h7
// field positions
`define FLT_SPD_MSB 7
`define FLT_BLAST_BIT 5
`define FLT_TIMER_BIT 4
`define STS_EN_MSB 7
`define STS_DIV_MSB 5
`define STS_ADDR_BIT 3
// reset values and fixed values
`define RST_ZERO 8'h00
`define RST_COUNT 8'hFF
`define RST_DRIVE 4'hF
`define RST_SETUP 4'h0
`define RST_DIV 2'h0
`define STS_LOW_BITS 3'h1
`define WORD_FILL 8'hFF
`define ADDR_FIXED 3'h7
`define COUNT_MAX 8'hFF
// timing
`define CLK_HZ 100000000
`define OSC_HZ 50000
`define OSC_CYCLES (`CLK_HZ / `OSC_HZ)
`define BLINK_MHZ 1500
// blink rate is in millihertz; the terms are ordered so the product stays inside 32 bits
`define BLINK_HALF_CYCLES ((`CLK_HZ / 10) * 100 / (2 * `BLINK_MHZ / 100))
`endif

// ==== rtl/fan_ctrl_pkg.sv ====
// types of the fan controller register and fault logic
package fan_ctrl_pkg;
    typedef struct packed {
        logic [2:0] ptr;
        logic [1:0] spd_en;
        logic [1:0] div;
        logic [7:0] lvl_a;
        logic [7:0] lvl_b;
        logic [3:0] drive;
        logic [3:0] blink_en;
        logic [3:0] chg_en;
        logic [1:0] flt_spd;
        logic blast;
        logic timer;
        logic [3:0] flt_pin;
        logic [3:0] ref_lvl;
        logic [1:0][7:0] cnt;
        logic [1:0] ovf;
        logic [1:0][7:0] cnt_reg;
        logic [1:0] tach_prev;
        logic [11:0] osc_cnt;
        logic [3:0] div_cnt;
        logic [25:0] blink_cnt;
        logic blink_ph;
        logic [7:0] rd_data;
        logic fault_pd;
        logic [3:0] pin_pd;
        logic [6:0] slave_addr;
    } fan_state_t;
endpackage

// ==== rtl/fan_ctrl_regs.sv ====
// register bank, speed counters and pin fault logic of the dual fan controller
//
// Notes on behaviour
// - fault register write clears faults, data dropped
// - speed fault sets when enabled and overflowed
// - speed fault latched; reasserts while still overflowed
// - blast and timer flags set on events
// - pin fault on level change after enable
// - fault write captures pin levels as reference
// - three-bit pointer selects one of eight registers
// - power-up loads every tabulated default
// - status D3 from address, D2..D0 read 001
// - oscillator divided by 2, 4, 8, 16
// - undervoltage forces both counts to all ones
// - count ticks between rising edges, then transfer
// - overflow loads 255 at once
// - pin state: upper pin levels, lower drive bits
// - drive one releases pull-down, zero enables it
// - drive bits come up high
// - blink toggles pull-down at about 1.5Hz
// - blink and change enables come up low
// - address, pointer, data bytes each acknowledged
// - level code unsigned, 0x80 is half scale
// - open address pins give address 1110010
// - word read second byte ones, write ignored
// - write committed only after valid acknowledge
// - fault pull-down on while any flag high
`timescale 1ns/1ps
`include "fan_ctrl_params.svh"

module fan_ctrl_regs
    import fan_ctrl_pkg::*;
#(
    parameter int BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES,
    parameter int OSC_CYCLES = `OSC_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ptr_load,
    input wire logic [2:0] ptr_in,
    input wire logic wr_commit,
    input wire logic [7:0] reg_wr_data,
    input wire logic second_byte,
    output logic [7:0] reg_rd_data,
    input wire logic [3:0] addr_code,
    output logic [6:0] slave_address,
    input wire logic blast_event,
    input wire logic timeout_event,
    input wire logic undervoltage_lockout,
    input wire logic speed_input_a,
    input wire logic speed_input_b,
    input wire logic [3:0] gpio_in,
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_oe,
    output logic fault_out,
    output logic fault_oe,
    output logic [7:0] current_out_a_level,
    output logic [7:0] current_out_b_level
);

    fan_state_t s, n;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // mask of divider bits that must all be set for one count tick
    function automatic logic [3:0] div_mask(input logic [1:0] d);
        case (d)
            2'h3: div_mask = 4'h1;
            2'h2: div_mask = 4'h3;
            2'h1: div_mask = 4'h7;
            default: div_mask = 4'hF;
        endcase
    endfunction

    // read multiplexer over the eight registers
    function automatic logic [7:0] rd_mux(input fan_state_t q, input logic [3:0] pins,
                                          input logic adr);
        case (q.ptr)
            `PTR_FAULT: rd_mux = {q.flt_spd, q.blast, q.timer, q.flt_pin};
            `PTR_STATUS: rd_mux = {q.spd_en, q.div, adr, `STS_LOW_BITS};
            `PTR_LVL_A: rd_mux = q.lvl_a;
            `PTR_LVL_B: rd_mux = q.lvl_b;
            `PTR_CNT_A: rd_mux = q.cnt_reg[1];
            `PTR_CNT_B: rd_mux = q.cnt_reg[0];
            `PTR_PIN_STATE: rd_mux = {pins, q.drive};
            `PTR_PIN_SETUP: rd_mux = {q.blink_en, q.chg_en};
            default: rd_mux = `RST_ZERO;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    logic fault_wr;
    logic data_wr;
    logic osc_tick;
    logic cnt_tick;
    logic [1:0] tach_in;
    logic [3:0] ref_base;
    logic [3:0] pin_set;
    logic [3:0] dmask;

    // the serial engine raises wr_commit only after the data acknowledge
    // has completed validly, so no bad byte ever lands here
    assign data_wr = wr_commit && !second_byte;
    assign fault_wr = data_wr && (s.ptr == `PTR_FAULT);
    assign tach_in = {speed_input_a, speed_input_b};
    assign dmask = div_mask(s.div);

    always_comb begin
        n = s;
        osc_tick = (s.osc_cnt == 12'(OSC_CYCLES - 1));
        cnt_tick = 1'b0;
        ref_base = s.ref_lvl;
        pin_set = 4'h0;

        // oscillator and divider chain feeding the count clock
        n.osc_cnt = osc_tick ? 12'h000 : s.osc_cnt + 12'h001;
        if (osc_tick) begin
            n.div_cnt = s.div_cnt + 4'h1;
            cnt_tick = ((s.div_cnt & dmask) == dmask);
        end

        // pointer survives the end of a write so a read returns it
        if (ptr_load) begin
            n.ptr = ptr_in;
        end

        // register writes; fault register data is never stored
        if (data_wr) begin
            case (s.ptr)
                // leave the pointer alone: one loaded in this same cycle must survive
                `PTR_FAULT: begin end
                `PTR_STATUS: begin
                    n.spd_en = reg_wr_data[`STS_EN_MSB -: 2];
                    n.div = reg_wr_data[`STS_DIV_MSB -: 2];
                end
                `PTR_LVL_A: n.lvl_a = reg_wr_data;
                `PTR_LVL_B: n.lvl_b = reg_wr_data;
                `PTR_PIN_STATE: n.drive = reg_wr_data[3:0];
                `PTR_PIN_SETUP: begin
                    n.blink_en = reg_wr_data[7:4];
                    n.chg_en = reg_wr_data[3:0];
                end
                default: begin end // count registers are read only
            endcase
        end

        // speed counters; index 1 is input a, index 0 is input b
        for (int i = 0; i < 2; i++) begin
            n.tach_prev[i] = tach_in[i];
            if (undervoltage_lockout) begin
                n.cnt[i] = `RST_ZERO;
                n.ovf[i] = 1'b0;
                n.cnt_reg[i] = `RST_COUNT;
            end else if (tach_in[i] && !s.tach_prev[i]) begin
                n.cnt_reg[i] = s.ovf[i] ? `RST_COUNT : s.cnt[i];
                n.cnt[i] = `RST_ZERO;
                n.ovf[i] = 1'b0;
            end else if (cnt_tick && !s.ovf[i]) begin
                if (s.cnt[i] == `COUNT_MAX) begin
                    n.ovf[i] = 1'b1;
                    n.cnt_reg[i] = `COUNT_MAX;
                end else begin
                    n.cnt[i] = s.cnt[i] + 8'h01;
                end
            end
            // set wins over the fault write, so a live overflow re-raises
            n.flt_spd[i] = (s.flt_spd[i] & ~fault_wr & n.spd_en[i])
                           | (n.spd_en[i] & s.ovf[i]);
        end

        // event flags; an event in the clearing cycle is kept
        n.blast = (s.blast & ~fault_wr) | blast_event;
        n.timer = (s.timer & ~fault_wr) | timeout_event;

        // pin change faults against a reference taken at enable or clear
        for (int i = 0; i < 4; i++) begin
            if (fault_wr || (n.chg_en[i] && !s.chg_en[i])) begin
                ref_base[i] = gpio_in[i];
            end
        end
        n.ref_lvl = ref_base;
        pin_set = n.chg_en & (gpio_in ^ ref_base);
        n.flt_pin = (s.flt_pin & ~{4{fault_wr}} & n.chg_en) | pin_set;

        // blink phase generator, free running
        if (s.blink_cnt == 26'(BLINK_HALF_CYCLES - 1)) begin
            n.blink_cnt = 26'h0000000;
            n.blink_ph = ~s.blink_ph;
        end else begin
            n.blink_cnt = s.blink_cnt + 26'h0000001;
        end

        // pin pull-downs: off for drive one, gated by blink phase
        n.pin_pd = ~n.drive & (~n.blink_en | {4{n.blink_ph}});

        // fault pin pull-down follows the whole flag byte
        n.fault_pd = |{n.flt_spd, n.blast, n.timer, n.flt_pin};

        // read data; second byte of a word read is all ones
        n.rd_data = second_byte ? `WORD_FILL : rd_mux(s, gpio_in, addr_code[0]);
        n.slave_addr = {`ADDR_FIXED, addr_code};
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.drive <= `RST_DRIVE;
            s.blink_en <= `RST_SETUP;
            s.chg_en <= `RST_SETUP;
            s.div <= `RST_DIV;
            s.ref_lvl <= 4'hF;
            s.cnt_reg[0] <= `RST_COUNT;
            s.cnt_reg[1] <= `RST_COUNT;
            s.slave_addr <= {`ADDR_FIXED, 4'h2};
        end else begin
            s <= n;
        end
    end

    // outputs straight from state flip-flops, except gpio_out and fault_out, which are tied low
    assign reg_rd_data = s.rd_data;
    assign slave_address = s.slave_addr;
    assign gpio_oe = s.pin_pd;
    assign gpio_out = 4'h0; // open drain only ever pulls low
    assign fault_oe = s.fault_pd;
    assign fault_out = 1'b0;
    assign current_out_a_level = s.lvl_a;
    assign current_out_b_level = s.lvl_b;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence lvl_a_write_s;
        wr_commit && !second_byte && (s.ptr == `PTR_LVL_A);
    endsequence

    sequence ptr_quiet_s;
        ptr_load ##1 (!ptr_load) [*3];
    endsequence

    flt_discard_a: assert property (fault_wr && !blast_event && !timeout_event
        |=> !s.blast && !s.timer)
        else $error("fault write did not clear event flags");

    // clearing the enable in the same write wins over the overflow
    spd_flt_a: assert property (s.ovf[1] && s.spd_en[1]
        && !(data_wr && (s.ptr == `PTR_STATUS)) |=> s.flt_spd[1])
        else $error("speed fault a not raised on overflow");

    spd_relatch_a: assert property (fault_wr && s.ovf[1] && s.spd_en[1]
        && !(data_wr && s.ptr == `PTR_STATUS) |=> s.flt_spd[1])
        else $error("speed fault a not reasserted");

    // flag and fault pull-down rise together one edge after the event
    event_flag_a: assert property (blast_event |=> s.blast && fault_oe)
        else $error("blast flag not set");

    pin_clear_a: assert property (fault_wr |=> s.flt_pin == 4'h0)
        else $error("pin faults not cleared on fault write");

    ovf_load_a: assert property ($rose(s.ovf[1]) |-> s.cnt_reg[1] == `COUNT_MAX)
        else $error("overflow did not load count register");

    undervoltage_lockout_force_a: assert property (undervoltage_lockout
        |=> (s.cnt_reg[0] == `RST_COUNT) && (s.cnt_reg[1] == `RST_COUNT))
        else $error("undervoltage did not force counts");

    drive_off_a: assert property (s.drive[0] |-> !gpio_oe[0])
        else $error("pull-down on with drive bit high");

    blink_off_a: assert property (s.blink_en[0] && !s.drive[0] && !s.blink_ph
        |-> !gpio_oe[0])
        else $error("pull-down on in blink off phase");

    fault_pin_a: assert property (fault_oe == |{s.flt_spd, s.blast, s.timer, s.flt_pin})
        else $error("fault pin does not follow flags");

    word_fill_a: assert property (second_byte |=> reg_rd_data == `WORD_FILL)
        else $error("second read byte not all ones");

    lvl_commit_a: assert property (lvl_a_write_s |=> current_out_a_level == $past(reg_wr_data))
        else $error("level a write not committed");

    ptr_keep_a: assert property (ptr_quiet_s |-> $stable(s.ptr))
        else $error("pointer changed without load");

    ////////////////////////////////////////////////////////////////////////
    // further checks on flags, counters and writes

    // rising edge on input a outside lockout
    sequence rise_a_s;
        !undervoltage_lockout && speed_input_a && !s.tach_prev[1];
    endsequence

    // fault register data never lands in any other register
    drop_data_a: assert property (fault_wr
        |=> $stable({s.spd_en, s.div, s.lvl_a, s.lvl_b, s.drive, s.blink_en, s.chg_en}))
        else $error("fault write changed a register");

    // the second byte of a word write is thrown away
    word_drop_a: assert property (wr_commit && second_byte
        |=> $stable({s.spd_en, s.div, s.lvl_a, s.lvl_b, s.drive, s.blink_en, s.chg_en}))
        else $error("second write byte was stored");

    // a speed fault can only be seen while its enable is set
    spd_gate_a: assert property (!s.spd_en[1] |-> !s.flt_spd[1])
        else $error("speed fault a without enable");

    // clearing the a enable drops its flag on the write edge
    spd_en_off_a: assert property (data_wr && (s.ptr == `PTR_STATUS)
        && !reg_wr_data[`STS_EN_MSB] |=> !s.flt_spd[1])
        else $error("speed fault a kept after enable cleared");

    // timer flag is raised by a watchdog time-out
    timer_set_a: assert property (timeout_event |=> s.timer)
        else $error("timer flag not set");

    // a pin change fault needs its enable
    pin_gate_a: assert property (!s.chg_en[0] |-> !s.flt_pin[0])
        else $error("pin fault without enable");

    // a level away from the reference raises the flag next edge
    pin_set_a: assert property (s.chg_en[0] && !fault_wr
        && !(data_wr && (s.ptr == `PTR_PIN_SETUP)) && (gpio_in[0] != s.ref_lvl[0])
        |=> s.flt_pin[0])
        else $error("pin change fault not raised");

    // the fault write takes the pins as the new reference
    ref_take_a: assert property (fault_wr |=> s.ref_lvl == $past(gpio_in))
        else $error("pin reference not captured");

    // clearing a change enable drops its flag on the write edge
    pin_en_off_a: assert property (data_wr && (s.ptr == `PTR_PIN_SETUP)
        && !reg_wr_data[0] |=> !s.flt_pin[0])
        else $error("pin fault kept after enable cleared");

    // oscillator divider stays inside its span
    osc_range_a: assert property (s.osc_cnt < 12'(OSC_CYCLES))
        else $error("oscillator count out of range");

    // the divide chain steps once per oscillator tick
    div_step_a: assert property (osc_tick |=> s.div_cnt == $past(s.div_cnt) + 4'h1)
        else $error("divider chain did not step");

    // an input edge restarts the counter from zero
    cnt_restart_a: assert property (rise_a_s |=> (s.cnt[1] == 8'h00) && !s.ovf[1])
        else $error("speed counter a not restarted");

    // an input edge moves the finished count to the register
    cnt_move_a: assert property (rise_a_s
        |=> s.cnt_reg[1] == ($past(s.ovf[1]) ? `COUNT_MAX : $past(s.cnt[1])))
        else $error("speed count a not transferred");

    // a loaded pointer is the one used from the next cycle on
    ptr_take_a: assert property (ptr_load |=> s.ptr == $past(ptr_in))
        else $error("pointer not loaded");

    // level b follows its write one edge later
    lvl_b_commit_a: assert property (data_wr && (s.ptr == `PTR_LVL_B)
        |=> current_out_b_level == $past(reg_wr_data))
        else $error("level b write not committed");

    // pull-down of a blinking driven-low pin is on in the on phase
    blink_on_a: assert property (s.blink_en[0] && !s.drive[0] && s.blink_ph
        |-> gpio_oe[0])
        else $error("pull-down off in blink on phase");

endmodule

// ==== testbench/fan_master_model.sv ====
// far-side model: serial engine handing pointer and data bytes to the register port
`timescale 1ns/1ps
module fan_master_model (
    input wire logic clk,
    output logic ptr_load,
    output logic [2:0] ptr_in,
    output logic wr_commit,
    output logic [7:0] reg_wr_data,
    output logic second_byte
);
    // idle values; data lines carry junk when not qualified
    initial begin
        ptr_load = 1'b0;
        ptr_in = 3'h5;
        wr_commit = 1'b0;
        reg_wr_data = 8'hA5;
        second_byte = 1'b0;
    end
    // pointer byte acknowledged: load it, the device keeps it for later reads
    task set_ptr(input logic [2:0] p);
        @(posedge clk);
        ptr_load <= 1'b1;
        ptr_in <= p;
        @(posedge clk);
        ptr_load <= 1'b0;
        ptr_in <= ~p;
    endtask
    // data byte goes out only after its acknowledge was valid
    task wr(input logic [2:0] p, input logic [7:0] d, input logic word2);
        set_ptr(p);
        wr_commit <= 1'b1;
        reg_wr_data <= d;
        second_byte <= word2;
        @(posedge clk);
        wr_commit <= 1'b0;
        reg_wr_data <= ~d;
        second_byte <= 1'b0;
    endtask
endmodule

// ==== testbench/test_fan_ctrl_register_fault_logic.sv ====
// self-checking bench of the fan controller register and fault logic
`timescale 1ns/1ps
module test_fan_ctrl_register_fault_logic;
    import fan_ctrl_pkg::*;
    logic clk, resetn, blast_event, timeout_event, undervoltage_lockout, speed_input_a;
    logic ptr_load, wr_commit, second_byte, fault_out, fault_oe;
    logic [2:0] ptr_in;
    logic speed_input_b;
    logic [3:0] gpio_in, gpio_out, gpio_oe, addr_code;
    logic [7:0] reg_wr_data, reg_rd_data, lvl_a, lvl_b, v;
    logic [6:0] slave_address;
    int errors, total_checks, hi;
    // {pointer, write data, expected read}
    localparam logic [23:0] ROWS [6] = '{24'h028080, 24'h035A5A, 24'h04AAFF,
        24'h070000, 24'h014041, 24'h06F5A5};
    localparam logic [7:0] RST [8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hAF, 8'h00};
    fan_master_model m (.clk(clk), .ptr_load(ptr_load), .ptr_in(ptr_in), .wr_commit(wr_commit),
        .reg_wr_data(reg_wr_data), .second_byte(second_byte));
    // short oscillator and blink spans keep the run brief
    fan_ctrl_regs #(.BLINK_HALF_CYCLES(8), .OSC_CYCLES(4)) dut (.clk(clk), .resetn(resetn),
        .ptr_load(ptr_load), .ptr_in(ptr_in), .wr_commit(wr_commit),
        .reg_wr_data(reg_wr_data), .second_byte(second_byte), .reg_rd_data(reg_rd_data),
        .addr_code(addr_code), .slave_address(slave_address), .blast_event(blast_event),
        .timeout_event(timeout_event), .undervoltage_lockout(undervoltage_lockout),
        .speed_input_a(speed_input_a), .speed_input_b(speed_input_b), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .fault_out(fault_out), .fault_oe(fault_oe),
        .current_out_a_level(lvl_a), .current_out_b_level(lvl_b));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task wrap_up();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // read waits out the pointer load plus the registered read mux
    task get(input logic [2:0] p);
        m.set_ptr(p);
        repeat (2) @(posedge clk);
        @(negedge clk);
        v = reg_rd_data;
    endtask
    task rd(input string n, input logic [2:0] p, input logic [7:0] e);
        get(p);
        check(n, v, e);
    endtask
    // tach edges spaced gap clocks apart, the last interval is a clean one
    task edges(input int gap);
        repeat (3) begin
            repeat (gap) @(posedge clk);
            speed_input_a <= 1'b1;
            speed_input_b <= 1'b1;
            @(posedge clk);
            speed_input_a <= 1'b0;
            speed_input_b <= 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        blast_event = 1'b0;
        timeout_event = 1'b0;
        undervoltage_lockout = 1'b0;
        speed_input_a = 1'b0;
        speed_input_b = 1'b0;
        addr_code = 4'h2;
        gpio_in = 4'hA;
        errors = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 8; i++) rd("reset", 3'(i), RST[i]);
        check("address", {1'b0, slave_address}, 8'h72);
        check("pin_oe", {4'h0, gpio_oe}, 8'h00);
        for (int i = 0; i < 6; i++) begin
            m.wr(ROWS[i][18:16], ROWS[i][15:8], 1'b0);
            rd("row", ROWS[i][18:16], ROWS[i][7:0]);
        end
        check("pin_oe", {4'h0, gpio_oe}, 8'h0A);
        check("level_a", lvl_a, 8'h80);
        check("level_b", lvl_b, 8'h5A);
        check("pin_out", {4'h0, gpio_out}, 8'h00);
        check("fault_out", {7'h0, fault_out}, 8'h00);
        m.wr(3'h2, 8'h33, 1'b1);
        rd("word_write", 3'h2, 8'h80);
        // blast and timer events latch until the fault register is written
        @(posedge clk) blast_event <= 1'b1;
        @(posedge clk) blast_event <= 1'b0;
        rd("blast", 3'h0, 8'h20);
        check("fault_oe", {7'h0, fault_oe}, 8'h01);
        m.wr(3'h0, 8'hFF, 1'b0);
        rd("clear", 3'h0, 8'h00);
        check("fault_oe", {7'h0, fault_oe}, 8'h00);
        @(posedge clk) timeout_event <= 1'b1;
        @(posedge clk) timeout_event <= 1'b0;
        rd("timer", 3'h0, 8'h10);
        m.wr(3'h0, 8'h00, 1'b0);
        // every divider code; ten ticks expected between edges, one tick of phase slack
        for (int d = 0; d < 4; d++) begin
            m.wr(3'h1, {2'h2, 2'(d), 4'h0}, 1'b0);
            edges(40 * (16 >> d));
            get(3'h4);
            check("count", 8'(v >= 9 && v <= 11), 8'h01);
            get(3'h5);
            check("count_b", 8'(v >= 9 && v <= 11), 8'h01);
        end
        repeat (2200) @(posedge clk);
        rd("overflow", 3'h4, 8'hFF);
        rd("speed_fault", 3'h0, 8'h80);
        m.wr(3'h0, 8'h00, 1'b0);
        rd("reassert", 3'h0, 8'h80);
        m.wr(3'h1, 8'h30, 1'b0);
        rd("enable_off", 3'h0, 8'h00);
        // another address pin code moves status D3 and the bus address
        @(posedge clk) addr_code <= 4'h5;
        rd("status_d3", 3'h1, 8'h39);
        check("address_b", {1'b0, slave_address}, 8'h75);
        edges(80);
        @(posedge clk) undervoltage_lockout <= 1'b1;
        repeat (2) @(posedge clk);
        undervoltage_lockout <= 1'b0;
        rd("lockout", 3'h4, 8'hFF);
        rd("lockout_b", 3'h5, 8'hFF);
        // pin change faults against the captured reference
        m.wr(3'h7, 8'h01, 1'b0);
        rd("no_change", 3'h0, 8'h00);
        @(posedge clk) gpio_in <= 4'hB;
        rd("pin_fault", 3'h0, 8'h01);
        m.wr(3'h0, 8'h00, 1'b0);
        rd("new_ref", 3'h0, 8'h00);
        @(posedge clk) gpio_in <= 4'hA;
        rd("ref_change", 3'h0, 8'h01);
        m.wr(3'h7, 8'h00, 1'b0);
        rd("pin_off", 3'h0, 8'h00);
        // blink toggles the pull-down of a driven-low pin
        m.wr(3'h6, 8'h0E, 1'b0);
        @(negedge clk);
        check("pin_oe", {4'h0, gpio_oe}, 8'h01);
        m.wr(3'h7, 8'h10, 1'b0);
        hi = 0;
        repeat (40) begin
            @(negedge clk);
            hi += int'(gpio_oe[0] === 1'b1);
        end
        // eight-cycle half period: 40 cycles hold 16 to 24 on-cycles
        check("blink", 8'(hi >= 16 && hi <= 24), 8'h01);
        wrap_up();
    end
    // cut a hang short well past the expected run length
    initial begin
        #200us;
        errors++;
        wrap_up();
    end
endmodule
